// File: hw/rpa_map.vh
// rewriter pipeline point/action constants: point positions, action codes, field widths
// assumes: included by the rewriter pipeline action design files and by its testbench files
`ifndef RPA_MAP_VH
`define RPA_MAP_VH

// ----------------------------------------
// pipeline point positions in the flow
// ----------------------------------------
`define RPA_PT_NONE 4'h0
`define RPA_PT_INNER_MIP 4'h1
`define RPA_PT_INNER_SW 4'h2
`define RPA_PT_INNER_SVC 4'h3
`define RPA_PT_OUTER_SVC 4'h4
`define RPA_PT_OUTER_SW 4'h5
`define RPA_PT_OUTER_MIP 4'h6
`define RPA_PT_TEST 4'h7
`define RPA_PT_PORT 4'h8
`define RPA_PT_REPLY 4'h9

// ----------------------------------------
// pipeline action codes
// ----------------------------------------
`define RPA_ACT_NONE 4'h0
`define RPA_ACT_INJ 4'h1
`define RPA_ACT_MASQUERADE_INJECT_ACTION 4'h2
`define RPA_ACT_CENTRAL_INJECT_ACTION 4'h3
`define RPA_ACT_XTR 4'h4
`define RPA_ACT_XTR_UP 4'h5
`define RPA_ACT_LBK_ANA 4'h6
`define RPA_ACT_QUEUE_LOOPBACK_ACTION 4'h7

// ----------------------------------------
// action type classes
// ----------------------------------------
`define RPA_TYPE_NONE 2'h0
`define RPA_TYPE_INJECT 2'h1
`define RPA_TYPE_EXTRACT 2'h2
`define RPA_TYPE_LOOPBACK 2'h3

// ----------------------------------------
// lookup field codes
// ----------------------------------------
`define RPA_LPT_INNER_SW 2'h0
`define RPA_LPT_OUTER_SW 2'h1
`define RPA_LPT_TEST 2'h2
`define RPA_FWD_NONE 2'h0
`define RPA_FWD_COPY 2'h1
`define RPA_FWD_REDIRECT_SELECT 2'h2
`define RPA_FWD_DISCARD 2'h3
`define RPA_LACT_XTR 1'b0
`define RPA_LACT_LBK 1'b1
`define RPA_ENCAP_ETH 2'h0
`define RPA_SRC_LOCAL_BIT 40
`define RPA_ADJ_W 6

`endif

// File: hw/rpa_action_class.v
// action class: maps a pipeline action code to its action type for rewriter handling
// assumes: purely combinational, used once per action source
`timescale 1ns/1ps
`include "rpa_map.vh"

module rpa_action_class (
	// action in
	input wire [3:0] action_i,
	// type out
	output reg [1:0] type_o
);

	// ----------------------------------------
	// classification
	// ----------------------------------------
	// queue loopback counts as injection, analyzer loopback as extraction
	always @* begin
		case (action_i)
			`RPA_ACT_INJ, `RPA_ACT_MASQUERADE_INJECT_ACTION, `RPA_ACT_CENTRAL_INJECT_ACTION: type_o = `RPA_TYPE_INJECT;
			`RPA_ACT_QUEUE_LOOPBACK_ACTION: type_o = `RPA_TYPE_INJECT;
			`RPA_ACT_XTR, `RPA_ACT_XTR_UP: type_o = `RPA_TYPE_EXTRACT;
			`RPA_ACT_LBK_ANA: type_o = `RPA_TYPE_EXTRACT;
			default: type_o = `RPA_TYPE_NONE;
		endcase
	end

endmodule

// File: hw/rpa_point_gate.v
// point gate: decides whether a stage at a given flow position may act and count
// assumes: current point/type come from the cleaned entry state or from the registered result state
`timescale 1ns/1ps
`include "rpa_map.vh"

module rpa_point_gate (
	// frame state
	input wire [3:0] cur_point_i,
	input wire [1:0] cur_type_i,
	// stage position
	input wire [3:0] stage_point_i,
	// verdict
	output wire active_o
);

	// ----------------------------------------
	// existence check
	// ----------------------------------------
	// injected later, absent earlier
	wire inj_block = (cur_type_i == `RPA_TYPE_INJECT) && (stage_point_i < cur_point_i);
	wire xtr_block = (cur_type_i == `RPA_TYPE_EXTRACT) && (stage_point_i > cur_point_i);
	assign active_o = !(inj_block || xtr_block);

endmodule

// File: hw/rpa_rewriter_action.v
// rewriter pipeline action decode: takes the first egress lookup action for a frame,
// resolves pipeline point/action, forwarding, mac edits and scheduler info
// assumes: one frame per frame_valid_i pulse from same-clock logic; mac table read
// is combinational (index out, address in the same cycle); results one cycle later
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "rpa_map.vh"

module rpa_rewriter_action #(
	parameter MAC_TABLE_INDEX_W = 7,
	parameter QUEUE_W = 3,
	parameter SCHED_W = 12
) (
	// clock and reset
	input wire clock_i,
	input wire reset_n_i,
	// frame entry state
	input wire frame_valid_i,
	input wire [3:0] in_point_i,
	input wire [3:0] in_action_i,
	input wire [1:0] post_encap_type_i,
	input wire [47:0] frame_dest_addr_i,
	input wire [47:0] frame_src_addr_i,
	// first lookup action fields
	input wire lookup_hit_i,
	input wire [1:0] flow_point_code_i,
	input wire flow_action_code_i,
	input wire [1:0] forward_selector_i,
	input wire [QUEUE_W-1:0] cpu_queue_select_i,
	input wire [MAC_TABLE_INDEX_W-1:0] mac_table_index_i,
	input wire dest_addr_replace_en_i,
	input wire addr_swap_en_i,
	input wire forced_loop_en_i,
	input wire [SCHED_W-1:0] scheduler_adjust_info_i,
	// mac table read port
	output wire [MAC_TABLE_INDEX_W-1:0] mac_table_addr_o,
	input wire [47:0] mac_table_data_i,
	// intermediate point and endpoint processor requests
	input wire mip_extract_i,
	input wire [3:0] mip_point_i,
	input wire vop_extract_up_i,
	input wire [3:0] vop_point_i,
	// stage gating query
	input wire [3:0] stage_point_i,
	output wire stage_active_o,
	// results
	output reg result_valid_o,
	output reg [3:0] out_point_o,
	output reg [3:0] out_action_o,
	output reg [1:0] out_type_o,
	output reg [1:0] out_forward_o,
	output reg cpu_queue_valid_o,
	output reg [QUEUE_W-1:0] cpu_queue_o,
	output reg [47:0] out_dest_addr_o,
	output reg [47:0] out_src_addr_o,
	output reg [SCHED_W-1:0] sched_info_o,
	output reg signed [`RPA_ADJ_W-1:0] sched_adj_l0_o,
	output reg signed [`RPA_ADJ_W-1:0] sched_adj_l1_o
);

	// ----------------------------------------
	// entry cleanup
	// ----------------------------------------
	wire [1:0] in_type;
	reg [3:0] ent_point;
	reg [3:0] ent_action;

	rpa_action_class u_in_class (
		.action_i(in_action_i),
		.type_o(in_type)
	);

	// injection actions are cleared on entry
	always @* begin
		ent_point = in_point_i;
		ent_action = in_action_i;
		if (in_type == `RPA_TYPE_INJECT) begin
			ent_point = `RPA_PT_NONE;
			ent_action = `RPA_ACT_NONE;
		end
	end

	wire [1:0] ent_type;

	rpa_action_class u_ent_class (
		.action_i(ent_action),
		.type_o(ent_type)
	);

	// ----------------------------------------
	// lookup field decode
	// ----------------------------------------
	reg [3:0] lk_point;
	reg lk_point_ok;
	reg [1:0] lk_fwd;
	reg lk_act;
	reg lk_swap;

	always @* begin
		lk_point_ok = 1'b1;
		case (flow_point_code_i)
			`RPA_LPT_INNER_SW: lk_point = `RPA_PT_INNER_SW;
			`RPA_LPT_OUTER_SW: lk_point = `RPA_PT_OUTER_SW;
			`RPA_LPT_TEST: lk_point = `RPA_PT_TEST;
			default: begin
				lk_point = `RPA_PT_NONE;
				lk_point_ok = 1'b0;
			end
		endcase
		lk_fwd = forward_selector_i;
		lk_act = flow_action_code_i;
		lk_swap = addr_swap_en_i;
		if (forced_loop_en_i) begin
			lk_fwd = `RPA_FWD_REDIRECT_SELECT;
			lk_act = `RPA_LACT_LBK;
			lk_point = `RPA_PT_TEST;
			lk_point_ok = 1'b1;
			lk_swap = 1'b1;
		end
	end

	// lookup may act only if the frame exists at its point
	wire lk_gate;

	rpa_point_gate u_lk_gate (
		.cur_point_i(ent_point),
		.cur_type_i(ent_type),
		.stage_point_i(lk_point),
		.active_o(lk_gate)
	);

	// ----------------------------------------
	// pipeline resolution
	// ----------------------------------------
	reg [3:0] pt_next;
	reg [3:0] act_next;
	reg [1:0] fwd_next;
	reg q_valid_next;
	reg swap_next;
	wire mip_gate;
	wire vop_gate;
	wire lk_apply = lookup_hit_i && lk_point_ok && lk_gate;

	always @* begin
		pt_next = ent_point;
		act_next = ent_action;
		fwd_next = `RPA_FWD_NONE;
		q_valid_next = 1'b0;
		swap_next = 1'b0;
		if (lk_apply && (lk_fwd != `RPA_FWD_NONE)) begin
			fwd_next = lk_fwd;
			q_valid_next = (lk_act == `RPA_LACT_XTR) && !forced_loop_en_i;
			// redirect and discard update point and action, copy leaves them
			if (lk_fwd != `RPA_FWD_COPY) begin
				pt_next = lk_point;
				act_next = (lk_act == `RPA_LACT_LBK && lk_fwd == `RPA_FWD_REDIRECT_SELECT) ?
					`RPA_ACT_LBK_ANA : `RPA_ACT_XTR;
			end
			swap_next = lk_swap && ((lk_fwd == `RPA_FWD_COPY) ||
				((lk_fwd == `RPA_FWD_REDIRECT_SELECT) && (lk_act == `RPA_LACT_LBK)));
		end
		// later points: intermediate point extract, then endpoint up extract
		if (mip_extract_i && mip_gate && (act_next == `RPA_ACT_NONE)) begin
			pt_next = mip_point_i;
			act_next = `RPA_ACT_XTR;
		end
		if (vop_extract_up_i && vop_gate && (act_next == `RPA_ACT_NONE)) begin
			pt_next = vop_point_i;
			act_next = `RPA_ACT_XTR_UP;
		end
	end

	// later points are gated by the cleaned entry state
	rpa_point_gate u_mip_gate (
		.cur_point_i(ent_point),
		.cur_type_i(ent_type),
		.stage_point_i(mip_point_i),
		.active_o(mip_gate)
	);

	rpa_point_gate u_vop_gate (
		.cur_point_i(ent_point),
		.cur_type_i(ent_type),
		.stage_point_i(vop_point_i),
		.active_o(vop_gate)
	);

	wire [1:0] next_type;

	rpa_action_class u_next_class (
		.action_i(act_next),
		.type_o(next_type)
	);

	// ----------------------------------------
	// mac address edits
	// ----------------------------------------
	// index drives table read
	assign mac_table_addr_o = mac_table_index_i;
	reg [47:0] dst_next;
	reg [47:0] src_next;

	always @* begin
		dst_next = frame_dest_addr_i;
		src_next = frame_src_addr_i;
		if (lookup_hit_i && dest_addr_replace_en_i && (post_encap_type_i == `RPA_ENCAP_ETH)) begin
			dst_next = mac_table_data_i;
		end
		if (swap_next) begin
			src_next = dst_next;
			dst_next = frame_src_addr_i;
			src_next[`RPA_SRC_LOCAL_BIT] = 1'b0;
		end
	end

	// ----------------------------------------
	// stage gating for counters
	// ----------------------------------------
	// frames always pass; only effects gated
	rpa_point_gate u_stage_gate (
		.cur_point_i(out_point_o),
		.cur_type_i(out_type_o),
		.stage_point_i(stage_point_i),
		.active_o(stage_active_o)
	);

	// ----------------------------------------
	// result registers
	// ----------------------------------------
	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			result_valid_o <= 1'b0;
			out_point_o <= `RPA_PT_NONE;
			out_action_o <= `RPA_ACT_NONE;
			out_type_o <= `RPA_TYPE_NONE;
			out_forward_o <= `RPA_FWD_NONE;
			cpu_queue_valid_o <= 1'b0;
			cpu_queue_o <= {QUEUE_W{1'b0}};
			out_dest_addr_o <= 48'h0000_0000_0000;
			out_src_addr_o <= 48'h0000_0000_0000;
			sched_info_o <= {SCHED_W{1'b0}};
			sched_adj_l0_o <= 6'sd0;
			sched_adj_l1_o <= 6'sd0;
		end else begin
			result_valid_o <= frame_valid_i;
			if (frame_valid_i) begin
				out_point_o <= pt_next;
				out_action_o <= act_next;
				out_type_o <= next_type;
				out_forward_o <= fwd_next;
				cpu_queue_valid_o <= q_valid_next;
				cpu_queue_o <= q_valid_next ? cpu_queue_select_i : {QUEUE_W{1'b0}};
				out_dest_addr_o <= dst_next;
				out_src_addr_o <= src_next;
				sched_info_o <= lookup_hit_i ? scheduler_adjust_info_i : {SCHED_W{1'b0}};
				sched_adj_l0_o <= lookup_hit_i ? scheduler_adjust_info_i[5:0] : 6'sd0;
				sched_adj_l1_o <= lookup_hit_i ? scheduler_adjust_info_i[11:6] : 6'sd0;
			end
		end
	end

endmodule

// File: tb/rpa_mac_table_model.sv
// mac table model on the block's read port
// assumes: read is combinational, entry derived from the index
`timescale 1ns/1ps
module rpa_mac_table_model (
	input wire logic [6:0] addr_i,
	output logic [47:0] data_o
);
	assign data_o = {8'h03, 33'h0_0000_0000, addr_i};
endmodule

// File: tb/rpa_action_properties.sv
// port relations of the rewriter action decode
// assumes: bound into rpa_rewriter_action, one clock, async low reset
`timescale 1ns/1ps
`include "rpa_map.vh"
module rpa_action_properties #(parameter MAC_TABLE_INDEX_W = 7, parameter SCHED_W = 12) (
	input logic clock_i, reset_n_i, frame_valid_i, lookup_hit_i, addr_swap_en_i,
	input logic forced_loop_en_i, mip_extract_i, vop_extract_up_i,
	input logic result_valid_o, stage_active_o, cpu_queue_valid_o,
	input logic [3:0] in_action_i, stage_point_i, out_point_o, out_action_o,
	input logic [1:0] post_encap_type_i, out_type_o, out_forward_o,
	input logic [47:0] frame_dest_addr_i, out_dest_addr_o,
	input logic [MAC_TABLE_INDEX_W-1:0] mac_table_index_i, mac_table_addr_o,
	input logic [SCHED_W-1:0] scheduler_adjust_info_i, sched_info_o,
	input logic signed [`RPA_ADJ_W-1:0] sched_adj_l0_o, sched_adj_l1_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	// frame taken with a lookup hit, and a frame with empty entry state
	sequence s_take;
		frame_valid_i && lookup_hit_i;
	endsequence
	sequence s_clean;
		in_action_i == `RPA_ACT_NONE && !mip_extract_i && !vop_extract_up_i;
	endsequence
	a_result_one_late: assert property (frame_valid_i |=> result_valid_o)
		else $error("result not one cycle after frame");
	a_no_stray_result: assert property (!frame_valid_i |=> !result_valid_o)
		else $error("result without frame");
	a_mac_index_path: assert property (mac_table_addr_o == mac_table_index_i)
		else $error("table address differs from index");
	a_sched_passthru: assert property (s_take |=> sched_info_o == $past(scheduler_adjust_info_i))
		else $error("scheduler info altered");
	a_adj_split: assert property (result_valid_o |-> sched_adj_l0_o == sched_info_o[5:0]
		&& sched_adj_l1_o == sched_info_o[11:6])
		else $error("adjustment split wrong");
	a_forced_loop: assert property (s_take ##0 s_clean ##0 forced_loop_en_i |=>
		out_forward_o == `RPA_FWD_REDIRECT_SELECT && out_point_o == `RPA_PT_TEST
		&& out_action_o == `RPA_ACT_LBK_ANA && !cpu_queue_valid_o)
		else $error("forced loop not applied");
	a_inject_clear: assert property (frame_valid_i && !lookup_hit_i && !mip_extract_i
		&& !vop_extract_up_i && in_action_i inside {`RPA_ACT_INJ, `RPA_ACT_MASQUERADE_INJECT_ACTION,
		`RPA_ACT_CENTRAL_INJECT_ACTION, `RPA_ACT_QUEUE_LOOPBACK_ACTION} |=> out_point_o == 0 && out_action_o == 0)
		else $error("injection state not cleared");
	a_eth_only: assert property (s_take ##0 post_encap_type_i != `RPA_ENCAP_ETH
		&& !addr_swap_en_i && !forced_loop_en_i |=> out_dest_addr_o == $past(frame_dest_addr_i))
		else $error("non ethernet destination changed");
	a_lbk_is_extract: assert property (result_valid_o && out_action_o == `RPA_ACT_LBK_ANA
		|-> out_type_o == `RPA_TYPE_EXTRACT)
		else $error("loopback not typed as extraction");
	a_late_stage_off: assert property (out_type_o == `RPA_TYPE_EXTRACT
		&& stage_point_i > out_point_o |-> !stage_active_o)
		else $error("stage active after extraction point");
endmodule
bind rpa_rewriter_action rpa_action_properties #(.MAC_TABLE_INDEX_W(MAC_TABLE_INDEX_W), .SCHED_W(SCHED_W))
	u_rpa_action_properties (.*);

// File: tb/rpa_rewriter_action_test.sv
// bench for the rewriter action decode
// assumes: mac table model on the read port, checker bound to the block
`timescale 1ns/1ps
`include "rpa_map.vh"
module rpa_rewriter_action_test;
	localparam [47:0] DA = 48'h0123_4567_89ab;
	localparam [47:0] SA = 48'h0200_0000_0055;
	logic clock_i = 0, reset_n_i = 0, fv = 0, hit = 0, lact = 0, rep = 0, swp = 0;
	logic lp = 0, mx = 0, vx = 0, rv, sact, qv;
	logic [3:0] ipt = 0, iact = 0, mpt = 0, vpt = 0, spt = 0, opt, oact;
	logic [1:0] enc = 0, lpt = 0, fwd = 0, oty, ofw;
	logic [2:0] q = 0, oq;
	logic [6:0] idx = 0, maddr;
	logic [11:0] si = 0, osi;
	logic [5:0] a0, a1;
	logic [47:0] mdat, oda, osa;
	integer fails = 0, check_count = 0;
	rpa_rewriter_action u_rpa_rewriter_action (
		.clock_i(clock_i), .reset_n_i(reset_n_i), .frame_valid_i(fv), .in_point_i(ipt),
		.in_action_i(iact), .post_encap_type_i(enc), .frame_dest_addr_i(DA),
		.frame_src_addr_i(SA), .lookup_hit_i(hit), .flow_point_code_i(lpt),
		.flow_action_code_i(lact), .forward_selector_i(fwd), .cpu_queue_select_i(q),
		.mac_table_index_i(idx), .dest_addr_replace_en_i(rep), .addr_swap_en_i(swp),
		.forced_loop_en_i(lp), .scheduler_adjust_info_i(si), .mac_table_addr_o(maddr),
		.mac_table_data_i(mdat), .mip_extract_i(mx), .mip_point_i(mpt),
		.vop_extract_up_i(vx), .vop_point_i(vpt), .stage_point_i(spt),
		.stage_active_o(sact), .result_valid_o(rv), .out_point_o(opt),
		.out_action_o(oact), .out_type_o(oty), .out_forward_o(ofw),
		.cpu_queue_valid_o(qv), .cpu_queue_o(oq), .out_dest_addr_o(oda),
		.out_src_addr_o(osa), .sched_info_o(osi), .sched_adj_l0_o(a0), .sched_adj_l1_o(a1)
	);
	rpa_mac_table_model u_rpa_mac_table_model (.addr_i(maddr), .data_o(mdat));
	// clock, 8 ns period
	initial forever #4 clock_i = ~clock_i;
	task chk(input [47:0] got, exp);
		check_count = check_count + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task stop_test;
		if (fails == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	function automatic [3:0] pmap(input [1:0] c);
		pmap = c == 0 ? `RPA_PT_INNER_SW : c == 1 ? `RPA_PT_OUTER_SW : `RPA_PT_TEST;
	endfunction
	// one frame pulse, outputs judged after the taking edge
	task run(input [3:0] p, a, input [1:0] f, c);
		@(posedge clock_i);
		ipt <= p; iact <= a; fwd <= f; lpt <= c; fv <= 1;
		@(posedge clock_i);
		fv <= 0;
		#1 chk(rv, 1);
	endtask
	task s_reset;
		#1 chk({opt, oact, ofw, rv}, 0);
	endtask
	// every selector, point code and action
	task s_lookup;
		integer f, c, a;
		hit <= 1; q <= 5;
		for (f = 0; f < 4; f++) for (c = 0; c < 3; c++) for (a = 0; a < 2; a++) begin
			lact <= a[0];
			run(0, 0, f[1:0], c[1:0]);
			chk(ofw, f);
			chk(opt, f > 1 ? pmap(c[1:0]) : 0);
			chk(oact, f < 2 ? 0 : (f == 2 && a) ? `RPA_ACT_LBK_ANA : `RPA_ACT_XTR);
			chk(oty, f > 1 ? `RPA_TYPE_EXTRACT : `RPA_TYPE_NONE);
			chk(qv, f > 0 && a == 0);
			chk(oq, (f > 0 && a == 0) ? 5 : 0);
		end
		run(0, 0, 2, 3);
		chk({opt, oact}, 0);
	endtask
	// injection entry state cleared, then intermediate and endpoint extraction
	task s_inject;
		integer i;
		logic [3:0] ia [4];
		ia = '{`RPA_ACT_INJ, `RPA_ACT_MASQUERADE_INJECT_ACTION, `RPA_ACT_CENTRAL_INJECT_ACTION, `RPA_ACT_QUEUE_LOOPBACK_ACTION};
		hit <= 0;
		for (i = 0; i < 4; i++) begin
			run(`RPA_PT_REPLY, ia[i], 0, 0);
			chk({opt, oact}, 0);
		end
		mx <= 1; mpt <= `RPA_PT_INNER_MIP;
		run(`RPA_PT_REPLY, `RPA_ACT_QUEUE_LOOPBACK_ACTION, 0, 0);
		chk({opt, oact}, {`RPA_PT_INNER_MIP, `RPA_ACT_XTR});
		mx <= 0; vx <= 1; vpt <= `RPA_PT_OUTER_SVC;
		run(`RPA_PT_REPLY, `RPA_ACT_INJ, 0, 0);
		chk({opt, oact}, {`RPA_PT_OUTER_SVC, `RPA_ACT_XTR_UP});
		vx <= 0;
	endtask
	// extracted early: later lookup and later stages are gated
	task s_gate;
		integer s;
		hit <= 1; lact <= 1;
		run(`RPA_PT_INNER_MIP, `RPA_ACT_XTR, 2, 2);
		chk({opt, oact, ofw}, {`RPA_PT_INNER_MIP, `RPA_ACT_XTR, 2'h0});
		for (s = 2; s < 10; s++) begin
			@(posedge clock_i) spt <= s;
			#1 chk(sact, 0);
		end
		hit <= 0;
		run(0, 0, 0, 0);
		for (s = 0; s < 10; s++) begin
			@(posedge clock_i) spt <= s;
			#1 chk(sact, 1);
		end
	endtask
	// replacement, swap and forced loop
	task s_mac;
		hit <= 1; lact <= 0; idx <= 7'h45; rep <= 1;
		run(0, 0, 0, 0);
		chk({oda, osa}, {8'h03, 33'h0_0000_0000, 7'h45, SA});
		enc <= 1;
		run(0, 0, 0, 0);
		chk(oda, DA);
		enc <= 0; rep <= 0; swp <= 1;
		run(0, 0, 1, 0);
		chk({oda, osa}, {SA, 48'h0023_4567_89ab});
		run(0, 0, 2, 0);
		chk(oda, DA);
		swp <= 0; lp <= 1;
		run(0, 0, 0, 0);
		chk({ofw, opt, oact, qv}, {`RPA_FWD_REDIRECT_SELECT, `RPA_PT_TEST, `RPA_ACT_LBK_ANA, 1'b0});
		chk({oda, osa}, {SA, 48'h0023_4567_89ab});
		lp <= 0;
	endtask
	// scheduler info at both ends of the signed ranges
	task s_sched;
		si <= 12'h0820;
		run(0, 0, 0, 0);
		chk({osi, a0, a1}, {12'h0820, 6'h20, 6'h20});
		si <= 12'h07df;
		run(0, 0, 0, 0);
		chk({osi, a0, a1}, {12'h07df, 6'h1f, 6'h1f});
	endtask
	initial begin
		repeat (6) @(posedge clock_i);
		reset_n_i <= 1;
		s_reset;
		s_lookup;
		s_inject;
		s_gate;
		s_mac;
		s_sched;
		stop_test;
	end
	// watchdog well beyond the expected run
	initial begin
		repeat (3000) @(posedge clock_i);
		fails = fails + 1;
		stop_test;
	end
endmodule
